// ### include/udcnt_pkg.sv
// Purpose: Shared constants and types of the up/down event counter.
// Assumes: 10 MHz system clock; one evaluation per clock edge.
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave.
`default_nettype none

package udcnt_pkg;

  // Build variants of the counter
  typedef enum logic [1:0] {
    UDC_UP_ONLY,
    UDC_DOWN_ONLY,
    UDC_UP_DOWN
  } udcnt_variant_type;

  // Clock and pulse-time figures
  localparam int unsigned UDCNT_CLK_HZ        = 10_000_000;
  localparam int unsigned UDCNT_CYC_PER_MS    = UDCNT_CLK_HZ / 1000;
  localparam int unsigned UDCNT_MIN_SHORT_MS  = 100;
  localparam int unsigned UDCNT_MIN_LONG_MS   = 350;
  localparam int unsigned UDCNT_MAX_PULSE_S   = 30;
  localparam int unsigned UDCNT_MIN_SHORT_CYC = UDCNT_MIN_SHORT_MS * UDCNT_CYC_PER_MS;
  localparam int unsigned UDCNT_MIN_LONG_CYC  = UDCNT_MIN_LONG_MS * UDCNT_CYC_PER_MS;
  localparam int unsigned UDCNT_MAX_PULSE_CYC = UDCNT_MAX_PULSE_S * UDCNT_CLK_HZ;

  // Widths
  localparam int UDCNT_CNT_W  = 16;
  localparam int UDCNT_TIME_W = 32;
  localparam int UDCNT_CTRL_W = 4;

  // Register byte offsets
  localparam logic [4:0] UDCNT_OFF_CTRL   = 5'h00;
  localparam logic [4:0] UDCNT_OFF_MAX    = 5'h04;
  localparam logic [4:0] UDCNT_OFF_START  = 5'h08;
  localparam logic [4:0] UDCNT_OFF_COUNT  = 5'h0c;
  localparam logic [4:0] UDCNT_OFF_STATUS = 5'h10;

  // Control and status field positions
  localparam int UDCNT_CTRL_AUTO_WRAP   = 0;
  localparam int UDCNT_CTRL_AUTO_RELOAD = 1;
  localparam int UDCNT_CTRL_CLR_LONG    = 2;
  localparam int UDCNT_CTRL_LD_LONG     = 3;
  localparam int UDCNT_STAT_UPPER       = 0;
  localparam int UDCNT_STAT_LOWER       = 1;

  // Positions in the synchronised pin vector
  localparam int UDCNT_PIN_UP   = 0;
  localparam int UDCNT_PIN_DOWN = 1;
  localparam int UDCNT_PIN_CLR  = 2;
  localparam int UDCNT_PIN_LD   = 3;

  // Values after reset, then the constant one (UDCNT_ONE)
  localparam logic [3:0]  UDCNT_CTRL_RST  = 4'h0;
  localparam logic [15:0] UDCNT_MAX_RST   = 16'hffff;
  localparam logic [15:0] UDCNT_START_RST = 16'h0001;
  localparam logic [15:0] UDCNT_COUNT_RST = 16'h0000;
  localparam logic        UDCNT_UPPER_RST = 1'b0;
  localparam logic        UDCNT_LOWER_RST = 1'b1;
  localparam logic [15:0] UDCNT_ONE       = 16'h0001;

endpackage

`default_nettype wire

// ### hdl/udcnt_pulse_qual.sv
// Purpose: Qualifies a low-high-low pulse by the length of its high time.
// Assumes: i_level is already synchronised to i_clk.
// Notes:   o_valid pulses one cycle after the falling edge is seen.
`timescale 1ns/1ps
`default_nettype none

module udcnt_pulse_qual
  import udcnt_pkg::*;
#(
  parameter int TIME_W = UDCNT_TIME_W
) (
  input  wire logic              i_clk,        // System clock
  input  wire logic              i_reset_n,    // Async reset, active low
  input  wire logic              i_level,      // Synchronised pulse input
  input  wire logic [TIME_W-1:0] i_min_cycles, // Least accepted high time
  input  wire logic [TIME_W-1:0] i_max_cycles, // Longest accepted high time
  output logic                   o_valid       // One-cycle accept pulse
);

  logic [TIME_W-1:0] cnt_q;
  logic [TIME_W-1:0] cnt_d;
  logic              level_q;
  logic              valid_d;

  // High-time counter saturates so a stuck-high pin never wraps to valid
  always_comb begin
    cnt_d   = '0;
    valid_d = 1'b0;
    if (i_level) begin
      cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + {{(TIME_W-1){1'b0}}, 1'b1};
    end else if (level_q) begin
      valid_d = (cnt_q >= i_min_cycles) && (cnt_q <= i_max_cycles); // RL5 RL7
    end
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= i_level;
      o_valid <= valid_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // A fall after an in-range high time is accepted next cycle
  property p_accept;
    (!i_level && level_q && cnt_q >= i_min_cycles && cnt_q <= i_max_cycles) |=> o_valid;
  endproperty
  a_accept: assert property (p_accept) else $error("in-range pulse not accepted"); // RL5

  // An accept only ever follows a fall with an in-range high time
  property p_only_in_range;
    o_valid |-> ($past(level_q) && !$past(i_level)
                 && $past(cnt_q) >= $past(i_min_cycles)
                 && $past(cnt_q) <= $past(i_max_cycles));
  endproperty
  a_only_in_range: assert property (p_only_in_range) else $error("bad pulse accepted"); // RL7

endmodule

`default_nettype wire

// ### hdl/udcnt_top.sv
// Purpose: Up/down event counter with qualified clear and load pulses.
// Assumes: Pins are asynchronous; registers reached over Avalon-MM.
// Notes:   One evaluation per clock edge; count pin delay is three cycles, clear and load act four cycles after their fall.
// What this block does
// [RL1] Up rising edge adds exactly one
// [RL2] Down rising edge subtracts exactly one
// [RL3] Both edges together leave count unchanged
// [RL4] Valid clear pulse forces count to zero
// [RL5] Clear high time within minimum and 30 s
// [RL6] Valid load pulse sets count to start
// [RL7] Load high time within minimum and 30 s
// [RL8] Maximum and start kept within 1..65535
// [RL9] Auto wrap: flag one cycle, then zero
// [RL10] Manual wrap: hold flag, ignore up counts
// [RL11] Auto reload: flag one cycle, then start
// [RL12] Manual reload: hold flag, ignore down counts
// [RL13] Clear and load beat up/down counts
// [RL14] Three variants; each uses its own inputs
// [RL15] Edges and widths measured in logic cycles
`timescale 1ns/1ps
`default_nettype none

module udcnt_top
  import udcnt_pkg::*;
#(
  parameter udcnt_variant_type VARIANT       = UDC_UP_DOWN,
  parameter int unsigned       MIN_SHORT_CYC = UDCNT_MIN_SHORT_CYC,
  parameter int unsigned       MIN_LONG_CYC  = UDCNT_MIN_LONG_CYC,
  parameter int unsigned       MAX_PULSE_CYC = UDCNT_MAX_PULSE_CYC
) (
  input  wire logic        i_clk,             // 10 MHz system clock
  input  wire logic        i_reset_n,         // Async reset, active low
  input  wire logic        i_count_up,        // Count-up pin
  input  wire logic        i_count_down,      // Count-down pin
  input  wire logic        i_clear,           // Clear-to-zero pin
  input  wire logic        i_load,            // Load-start-value pin
  input  wire logic [4:0]  i_avs_address,     // Byte address
  input  wire logic        i_avs_read,        // Read request
  input  wire logic        i_avs_write,       // Write request
  input  wire logic [31:0] i_avs_writedata,   // Write data
  input  wire logic [3:0]  i_avs_byteenable,  // Write byte lanes
  output logic [31:0]      o_avs_readdata,    // Read data, registered
  output logic             o_avs_waitrequest, // Stall, registered
  output logic [15:0]      o_count,           // Internal count
  output logic             o_upper,           // Maximum reached flag
  output logic             o_lower            // Zero reached flag
);

  // Variant gating: a missing direction is simply never seen
  localparam logic UP_EN = (VARIANT != UDC_DOWN_ONLY); // RL14
  localparam logic DN_EN = (VARIANT != UDC_UP_ONLY);   // RL14

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    merge = res;
  endfunction

  // Zero is out of range; it is stored as one
  function automatic logic [15:0] in_range(input logic [15:0] v);
    in_range = (v == '0) ? UDCNT_ONE : v; // RL8
  endfunction

  logic [3:0]  pin_vec;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  prev_q;
  logic        up_evt;
  logic        dn_evt;
  logic        clr_ok;
  logic        ld_ok;
  logic        quiet;
  logic [31:0] clr_min;
  logic [31:0] ld_min;
  logic [31:0] pulse_max;

  logic [3:0]  ctrl_q;
  logic [3:0]  ctrl_d;
  logic [15:0] max_q;
  logic [15:0] max_d;
  logic [15:0] start_q;
  logic [15:0] start_d;
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_d;
  logic        wr_go;
  logic [31:0] wr_word;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic        upper_q;
  logic        upper_d;
  logic        lower_q;
  logic        lower_d;
  logic        auto_wrap;
  logic        auto_reload;

  assign pin_vec = {i_load, i_clear, i_count_down, i_count_up};

  // Two-flop synchronisers, then a third stage for edge compare
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end else begin
      sync1_q <= pin_vec;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Rising edge: now high, low one logic cycle ago
  assign up_evt = UP_EN & sync2_q[UDCNT_PIN_UP] & ~prev_q[UDCNT_PIN_UP];     // RL15
  assign dn_evt = DN_EN & sync2_q[UDCNT_PIN_DOWN] & ~prev_q[UDCNT_PIN_DOWN]; // RL15

  // Minimum high time picked per input by control bits
  assign clr_min   = ctrl_q[UDCNT_CTRL_CLR_LONG] ? MIN_LONG_CYC : MIN_SHORT_CYC; // RL5
  assign ld_min    = ctrl_q[UDCNT_CTRL_LD_LONG] ? MIN_LONG_CYC : MIN_SHORT_CYC;  // RL7
  assign pulse_max = MAX_PULSE_CYC;

  // Width qualifiers for the clear and load pins
  udcnt_pulse_qual #(
    .TIME_W       (UDCNT_TIME_W)
  ) u_clr_qual (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_level      (sync2_q[UDCNT_PIN_CLR]),
    .i_min_cycles (clr_min),
    .i_max_cycles (pulse_max),
    .o_valid      (clr_ok)
  );

  udcnt_pulse_qual #(
    .TIME_W       (UDCNT_TIME_W)
  ) u_ld_qual (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_level      (sync2_q[UDCNT_PIN_LD]),
    .i_min_cycles (ld_min),
    .i_max_cycles (pulse_max),
    .o_valid      (ld_ok)
  );

  assign auto_wrap   = ctrl_q[UDCNT_CTRL_AUTO_WRAP];
  assign auto_reload = ctrl_q[UDCNT_CTRL_AUTO_RELOAD];
  assign quiet       = !clr_ok && !ld_ok;

  // Bus slave: one wait cycle, then answer; write lands on the answer edge
  always_comb begin
    wait_d  = !((i_avs_read || i_avs_write) && wait_q);
    wr_go   = i_avs_write && !wait_q;
    rdata_d = o_avs_readdata;
    ctrl_d  = ctrl_q;
    max_d   = max_q;
    start_d = start_q;
    wr_word = 32'h0000_0000;
    if (i_avs_read && wait_q) begin
      rdata_d = 32'h0000_0000;
      if (hit(i_avs_address, UDCNT_OFF_CTRL)) begin
        rdata_d[3:0] = ctrl_q;
      end else if (hit(i_avs_address, UDCNT_OFF_MAX)) begin
        rdata_d[15:0] = max_q;
      end else if (hit(i_avs_address, UDCNT_OFF_START)) begin
        rdata_d[15:0] = start_q;
      end else if (hit(i_avs_address, UDCNT_OFF_COUNT)) begin
        rdata_d[15:0] = count_q;
      end else if (hit(i_avs_address, UDCNT_OFF_STATUS)) begin
        rdata_d[UDCNT_STAT_UPPER] = upper_q;
        rdata_d[UDCNT_STAT_LOWER] = lower_q;
      end
    end
    if (wr_go) begin
      if (hit(i_avs_address, UDCNT_OFF_CTRL)) begin
        wr_word = merge({28'h0000000, ctrl_q}, i_avs_writedata, i_avs_byteenable);
        ctrl_d  = wr_word[3:0];
      end else if (hit(i_avs_address, UDCNT_OFF_MAX)) begin
        wr_word = merge({16'h0000, max_q}, i_avs_writedata, i_avs_byteenable);
        max_d   = in_range(wr_word[15:0]); // RL8
      end else if (hit(i_avs_address, UDCNT_OFF_START)) begin
        wr_word = merge({16'h0000, start_q}, i_avs_writedata, i_avs_byteenable);
        start_d = in_range(wr_word[15:0]); // RL8
      end
    end
  end

  // Bus and configuration registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_q         <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      ctrl_q         <= UDCNT_CTRL_RST;
      max_q          <= UDCNT_MAX_RST;
      start_q        <= UDCNT_START_RST;
    end else begin
      wait_q         <= wait_d;
      o_avs_readdata <= rdata_d;
      ctrl_q         <= ctrl_d;
      max_q          <= max_d;
      start_q        <= start_d;
    end
  end

  assign o_avs_waitrequest = wait_q;

  // Counter: clear, load, auto actions, then counts, in that priority
  always_comb begin
    count_d = count_q;
    if (clr_ok) begin
      count_d = '0; // RL4 RL13
    end else if (ld_ok) begin
      count_d = start_q; // RL6 RL13
    end else if (auto_wrap && count_q == max_q) begin
      count_d = '0; // RL9
    end else if (auto_reload && count_q == '0) begin
      count_d = start_q; // RL11
    end else if (up_evt && dn_evt) begin
      count_d = count_q; // RL3
    end else if (up_evt) begin
      if (count_q < max_q) begin
        count_d = count_q + UDCNT_ONE; // RL1 RL10
      end
    end else if (dn_evt) begin
      if (count_q != '0) begin
        count_d = count_q - UDCNT_ONE; // RL2 RL12
      end
    end
    // Flags follow the new count, so each stands while the count sits there
    upper_d = (count_d == max_q); // RL9 RL10
    lower_d = (count_d == '0);    // RL11 RL12
  end

  // Count and flag registers; zero flag starts high with the zero count
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= UDCNT_COUNT_RST;
      upper_q <= UDCNT_UPPER_RST;
      lower_q <= UDCNT_LOWER_RST;
    end else begin
      count_q <= count_d;
      upper_q <= upper_d;
      lower_q <= lower_d;
    end
  end

  assign o_count = count_q;
  assign o_upper = upper_q;
  assign o_lower = lower_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // Plain up count below the maximum
  property p_up;
    quiet && up_evt && !dn_evt && count_q < max_q && !(auto_reload && count_q == '0)
      |=> count_q == $past(count_q) + UDCNT_ONE;
  endproperty
  a_up: assert property (p_up) else $error("up edge did not add one"); // RL1

  // Plain down count above zero
  property p_down;
    quiet && dn_evt && !up_evt && count_q != '0 && !(auto_wrap && count_q == max_q)
      |=> count_q == $past(count_q) - UDCNT_ONE;
  endproperty
  a_down: assert property (p_down) else $error("down edge did not subtract one"); // RL2

  // Simultaneous edges cancel
  property p_both;
    quiet && up_evt && dn_evt && !(auto_wrap && count_q == max_q)
      && !(auto_reload && count_q == '0) |=> $stable(count_q);
  endproperty
  a_both: assert property (p_both) else $error("two edges changed count"); // RL3

  // Clear wins over everything
  property p_clear;
    clr_ok |=> count_q == '0 && lower_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero count"); // RL4 RL13

  // Load wins over counts
  property p_load;
    ld_ok && !clr_ok |=> count_q == $past(start_q);
  endproperty
  a_load: assert property (p_load) else $error("load did not set start"); // RL6 RL13

  // Stored limits never leave their range
  property p_range;
    max_q != '0 && start_q != '0;
  endproperty
  a_range: assert property (p_range) else $error("limit out of range"); // RL8

  // Auto wrap: at the maximum, zero next, flag gone the cycle after
  sequence s_wrapped;
    count_q == '0 ##1 !upper_q;
  endsequence
  property p_auto_wrap;
    quiet && auto_wrap && count_q == max_q && $stable(max_q) ##1 quiet && !up_evt
      |-> s_wrapped;
  endproperty
  a_auto_wrap: assert property (p_auto_wrap) else $error("auto wrap failed"); // RL9

  // Manual wrap: further up counts hold count and flag
  property p_hold_max;
    quiet && !auto_wrap && upper_q && count_q == max_q && !dn_evt
      |=> $stable(count_q) && upper_q;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("max not held"); // RL10

  // Auto reload: at zero, start value next
  sequence s_reloaded;
    count_q == $past(start_q) && !lower_q;
  endsequence
  property p_auto_reload;
    quiet && auto_reload && count_q == '0 && !(auto_wrap && max_q == '0) |=> s_reloaded;
  endproperty
  a_auto_reload: assert property (p_auto_reload) else $error("auto reload failed"); // RL11

  // Manual reload: further down counts hold zero and flag
  property p_hold_zero;
    quiet && !auto_reload && lower_q && count_q == '0 && !up_evt
      |=> count_q == '0 && lower_q;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("zero not held"); // RL12

  // A variant never sees the other direction
  property p_variant;
    !(VARIANT == UDC_UP_ONLY && dn_evt) && !(VARIANT == UDC_DOWN_ONLY && up_evt);
  endproperty
  a_variant: assert property (p_variant) else $error("foreign count input used"); // RL14

  // An up event is a low-to-high change between logic cycles
  property p_edge;
    up_evt |-> sync2_q[UDCNT_PIN_UP] && !$past(sync2_q[UDCNT_PIN_UP]);
  endproperty
  a_edge: assert property (p_edge) else $error("up event without edge"); // RL15

  // Every request is answered on the next edge
  property p_bus;
    (i_avs_read || i_avs_write) && wait_q |=> !o_avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");

endmodule

`default_nettype wire

// ### bench/udcnt_top_bench.sv
// Purpose: Self-checking bench of the up/down event counter.
// Assumes: Up/down variant plus a down-only build; pulse limits shortened to 10, 35 and 300 cycles.
// Notes:   Pins and bus change by non-blocking updates just after rising edges.
`timescale 1ns/1ps
`default_nettype none

module udcnt_top_bench
  import udcnt_pkg::*;
;
  localparam int unsigned MINS  = 10;
  localparam int unsigned MINL  = 35;
  localparam int unsigned MAXP  = 300;
  localparam int          LIMIT = 20000; // Whole run needs well under 5000 cycles

  logic        i_clk;
  logic        i_reset_n;
  logic [3:0]  pins;
  logic [4:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [15:0] o_count;
  logic        o_upper;
  logic        o_lower;
  logic [15:0] o_count_dn;
  int          fail_count;
  int          samples_checked;
  int          cycles;
  logic [15:0] exp_cnt;
  logic [15:0] mx;
  logic [31:0] seed;
  logic [31:0] rdat;

  udcnt_top #(
    .VARIANT       (UDC_UP_DOWN),
    .MIN_SHORT_CYC (MINS),
    .MIN_LONG_CYC  (MINL),
    .MAX_PULSE_CYC (MAXP)
  ) i_udcnt_top (
    .i_clk             (i_clk),
    .i_reset_n         (i_reset_n),
    .i_count_up        (pins[UDCNT_PIN_UP]),
    .i_count_down      (pins[UDCNT_PIN_DOWN]),
    .i_clear           (pins[UDCNT_PIN_CLR]),
    .i_load            (pins[UDCNT_PIN_LD]),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .o_count           (o_count),
    .o_upper           (o_upper),
    .o_lower           (o_lower)
  );

  // Down-only build on the same pins; its bus stays idle
  udcnt_top #(
    .VARIANT       (UDC_DOWN_ONLY),
    .MIN_SHORT_CYC (MINS),
    .MIN_LONG_CYC  (MINL),
    .MAX_PULSE_CYC (MAXP)
  ) i_udcnt_top_dn (
    .i_clk             (i_clk),
    .i_reset_n         (i_reset_n),
    .i_count_up        (pins[UDCNT_PIN_UP]),
    .i_count_down      (pins[UDCNT_PIN_DOWN]),
    .i_clear           (pins[UDCNT_PIN_CLR]),
    .i_load            (pins[UDCNT_PIN_LD]),
    .i_avs_address     (5'h00),
    .i_avs_read        (1'b0),
    .i_avs_write       (1'b0),
    .i_avs_writedata   (32'h0000_0000),
    .i_avs_byteenable  (4'h0),
    .o_avs_readdata    (),
    .o_avs_waitrequest (),
    .o_count           (o_count_dn),
    .o_upper           (),
    .o_lower           ()
  );

  // 10 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Next random word; fixed start keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected count in manual modes after one count event
  function automatic logic [15:0] model(input logic [15:0] c, input logic [15:0] m,
                                        input logic up, input logic dn);
    if (up && dn) return c;
    if (up) return (c >= m) ? c : c + 16'h0001;
    if (dn) return (c == 16'h0000) ? c : c - 16'h0001;
    return c;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One bus access; waitrequest and read data are taken at the rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address    <= a;
    i_avs_writedata  <= d;
    i_avs_byteenable <= be;
    i_avs_write      <= wr;
    i_avs_read       <= !wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask

  // Pins in mask high for w cycles, then low long enough to settle
  task automatic pulse(input logic [3:0] m, input int w);
    @(posedge i_clk);
    pins <= pins | m;
    repeat (w) @(posedge i_clk);
    pins <= pins & ~m;
    repeat (6) @(posedge i_clk);
  endtask

  // Looks off the edge so no launch races the compare
  task automatic chk_all;
    @(negedge i_clk);
    chk("count", {16'h0, exp_cnt}, {16'h0, o_count});
    chk("upper", {31'h0, exp_cnt == mx}, {31'h0, o_upper});
    chk("lower", {31'h0, exp_cnt == 16'h0}, {31'h0, o_lower});
  endtask

  task automatic step(input logic [3:0] m);
    pulse(m, 2);
    exp_cnt = model(exp_cnt, mx, m[UDCNT_PIN_UP], m[UDCNT_PIN_DOWN]);
    chk_all();
  endtask

  task automatic qpulse(input logic [3:0] m, input int w, input logic [15:0] e);
    pulse(m, w);
    exp_cnt = e;
    chk_all();
  endtask

  // Waits a bounded time for a count value, then checks a flag there
  task automatic wait_cnt(input logic [15:0] v, input logic f, input logic e);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_count !== v && n < 20);
    chk("count reached", {16'h0, v}, {16'h0, o_count});
    chk("flag at threshold", {31'h0, e}, {31'h0, f ? o_upper : o_lower});
  endtask

  // Hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    i_reset_n = 1'b0;
    pins = 4'h0;
    i_avs_address = 5'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    seed = 32'hc93b4bd8;
    exp_cnt = 16'h0000;
    mx = 16'hffff;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    chk_all();
    rd_chk("ctrl", UDCNT_OFF_CTRL, 32'h0);
    rd_chk("max", UDCNT_OFF_MAX, 32'h0000ffff);
    rd_chk("start", UDCNT_OFF_START, 32'h1);
    rd_chk("status", UDCNT_OFF_STATUS, 32'h2);
    rd_chk("unmapped", 5'h14, 32'h0);
    bus(1'b1, UDCNT_OFF_MAX, 32'h7, 4'h1, rdat);
    rd_chk("max lane", UDCNT_OFF_MAX, 32'h0000ff07);
    wr(UDCNT_OFF_MAX, 32'h0);
    rd_chk("max zero", UDCNT_OFF_MAX, 32'h1);
    wr(UDCNT_OFF_START, 32'h0);
    rd_chk("start zero", UDCNT_OFF_START, 32'h1);
    wr(UDCNT_OFF_COUNT, 32'h5);
    rd_chk("count ro", UDCNT_OFF_COUNT, 32'h0);
    $display("test registers done");
    // Manual thresholds: saturate at both ends
    mx = 16'h0005;
    wr(UDCNT_OFF_MAX, 32'h5);
    wr(UDCNT_OFF_START, 32'h3);
    repeat (6) step(4'h1);
    chk("down-only count", 32'h0, {16'h0, o_count_dn});
    step(4'h2);
    step(4'h3);
    repeat (5) step(4'h2);
    step(4'h1);
    $display("test manual counting done");
    qpulse(4'h8, MINS / 2, 16'h1);
    qpulse(4'h8, MINS + 2, 16'h3);
    step(4'h1);
    qpulse(4'h8, MAXP + 20, 16'h4);
    qpulse(4'h4, MINS / 2, 16'h4);
    qpulse(4'h4, MAXP + 20, 16'h4);
    step(4'h1);
    qpulse(4'h8, MINS + 2, 16'h3);
    qpulse(4'h4, MINS + 2, 16'h0);
    wr(UDCNT_OFF_CTRL, 32'hc);
    qpulse(4'h8, MINL - 15, 16'h0);
    qpulse(4'h8, MINL + 5, 16'h3);
    qpulse(4'h4, MINL - 15, 16'h3);
    qpulse(4'h4, MINL + 5, 16'h0);
    wr(UDCNT_OFF_CTRL, 32'h0);
    qpulse(4'h8, MINS + 2, 16'h3);
    qpulse(4'hc, MINS + 2, 16'h0);
    step(4'h1);
    // Clear accepted at the same edge as an up edge
    @(posedge i_clk);
    pins[UDCNT_PIN_CLR] <= 1'b1;
    repeat (MINS + 2) @(posedge i_clk);
    pins[UDCNT_PIN_CLR] <= 1'b0;
    // Up rises one edge after the fall, so both act in one evaluation
    pulse(4'h1, 2);
    exp_cnt = 16'h0;
    chk_all();
    $display("test clear and load done");
    // Random count traffic against a small random maximum
    seed = lfsr(seed);
    mx = {13'h0, seed[2:0]} + 16'h2;
    wr(UDCNT_OFF_MAX, {16'h0, mx});
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      step((seed[1:0] == 2'b01) ? 4'h2 : (seed[1:0] == 2'b10) ? 4'h3 : 4'h1);
    end
    $display("test random counting done");
    // Automatic wrap at maximum
    qpulse(4'h4, MINS + 2, 16'h0);
    mx = 16'h0003;
    wr(UDCNT_OFF_MAX, 32'h3);
    wr(UDCNT_OFF_CTRL, 32'h1);
    repeat (2) step(4'h1);
    @(posedge i_clk);
    pins[UDCNT_PIN_UP] <= 1'b1;
    wait_cnt(16'h3, 1'b1, 1'b1);
    @(negedge i_clk);
    chk("count wrapped", 32'h0, {16'h0, o_count});
    chk("upper one cycle", 32'h0, {31'h0, o_upper});
    @(posedge i_clk);
    pins[UDCNT_PIN_UP] <= 1'b0;
    repeat (4) @(posedge i_clk);
    // Automatic reload at zero
    wr(UDCNT_OFF_START, 32'h2);
    wr(UDCNT_OFF_CTRL, 32'h2);
    wait_cnt(16'h2, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    exp_cnt = 16'h2;
    step(4'h2);
    @(posedge i_clk);
    pins[UDCNT_PIN_DOWN] <= 1'b1;
    wait_cnt(16'h0, 1'b0, 1'b1);
    @(negedge i_clk);
    chk("count reloaded", 32'h2, {16'h0, o_count});
    chk("lower one cycle", 32'h0, {31'h0, o_lower});
    @(posedge i_clk);
    pins[UDCNT_PIN_DOWN] <= 1'b0;
    $display("test automatic modes done");
    wrap_up();
  end
endmodule

`default_nettype wire
